// File: shared/static_mem_pkg.sv
package static_mem_pkg;

	// ------------------------------------------------------------
	// memory kinds and host sizes
	// ------------------------------------------------------------
	localparam logic [1:0] MEM_SRAM  = 2'h0;	// asynchronous sram / rom
	localparam logic [1:0] MEM_PSRAM = 2'h1;	// pseudo static ram
	localparam logic [1:0] MEM_NOR   = 2'h2;	// nor flash
	localparam logic [1:0] SIZE_8    = 2'h0;	// byte access
	localparam logic [1:0] SIZE_16   = 2'h1;	// half word access
	localparam logic [1:0] SIZE_32   = 2'h2;	// word access, split in two

	// ------------------------------------------------------------
	// bank decode and address field positions
	// ------------------------------------------------------------
	localparam logic [1:0] BANK_SEL_1 = 2'h0;	// host bits 27:26 for select 1
	localparam logic [1:0] BANK_SEL_4 = 2'h3;	// host bits 27:26 for select 4
	localparam int BANK_MSB  = 27;			// top bit of bank field
	localparam int BANK_LSB  = 26;			// low bit of bank field
	localparam int HADDR_MSB = 23;			// top host bit issued

	// ------------------------------------------------------------
	// timing counts in bus clock cycles, sync latency in memory clocks
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_SETUP_CYCLES = 8'h02;	// address phase
	localparam logic [7:0] ADDR_HOLD_CYCLES  = 8'h02;	// muxed address hold
	localparam logic [7:0] DATA_SETUP_CYCLES = 8'h04;	// strobe low phase
	localparam logic [7:0] TURN_CYCLES       = 8'h01;	// bus turnaround
	localparam logic [7:0] SYNC_LATENCY      = 8'h02;	// memory clocks to data
	localparam logic [3:0] CLK_DIV           = 4'h4;	// bus clocks per mem clock
	localparam logic [3:0] CLK_HALF          = 4'h2;	// mem clock low part

	// ------------------------------------------------------------
	// access state machine
	// ------------------------------------------------------------
	typedef enum logic [8:0] {
		S_IDLE    = 9'h001,
		S_ADDR    = 9'h002,
		S_MUXHOLD = 9'h004,
		S_DATA    = 9'h008,
		S_TURN    = 9'h010,
		S_SADDR   = 9'h020,
		S_SLAT    = 9'h040,
		S_SBEAT   = 9'h080,
		S_SPARE   = 9'h100
	} access_e;

	typedef struct packed {
		access_e     state;	// access phase
		logic [7:0]  cnt;	// phase cycle counter
		logic [22:0] waddr;	// word address
		logic [31:0] wdata;	// host write data
		logic [31:0] rdata;	// gathered read data
		logic        write;	// access direction
		logic [1:0]  size;	// host size
		logic        half;	// second half word
		logic        cs4;	// sub bank 4 chosen
		logic [1:0]  lanes;	// byte lanes wanted, high active
		logic        clk_en;	// memory clock running
		logic        resp_valid;
		logic        resp_error;
		logic        cs1_n;
		logic        cs4_n;
		logic        oe_n;
		logic        we_n;
		logic        adv_n;
		logic [1:0]  lanes_n;
		logic [7:0]  a_hi;
		logic        a0;
		logic [15:0] dout;
		logic        d_oe_n;
	} access_s;

	localparam access_s ACCESS_RESET = '{
		state: S_IDLE, cnt: 8'h00, waddr: 23'h000000, wdata: 32'h00000000,
		rdata: 32'h00000000, write: 1'b0, size: 2'h0, half: 1'b0, cs4: 1'b0,
		lanes: 2'h0, clk_en: 1'b0, resp_valid: 1'b0, resp_error: 1'b0,
		cs1_n: 1'b1, cs4_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, adv_n: 1'b1,
		lanes_n: 2'h3, a_hi: 8'h00, a0: 1'b0, dout: 16'h0000, d_oe_n: 1'b1
	};

	typedef struct packed {
		logic [3:0] cnt;	// divider phase
		logic       mem_clk;	// clock level
		logic       rise;	// clock just went high
		logic       fall;	// clock just went low
	} divider_s;

	localparam divider_s DIVIDER_RESET = '{cnt: 4'h0, mem_clk: 1'b0, rise: 1'b0, fall: 1'b0};

endpackage

// File: logic/sync_stage.sv
`timescale 1ns/1ps
module sync_stage
	import static_mem_pkg::*;
#(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             resetn,
	// pins in, synchronised out
	input  wire logic [WIDTH-1:0] pin_in,
	input  wire logic [WIDTH-1:0] reset_val,
	output logic      [WIDTH-1:0] sync_out
);

	// ------------------------------------------------------------
	// two flop chain, first stage read only by the second
	// ------------------------------------------------------------
	typedef struct packed {
		logic [WIDTH-1:0] meta;	// may be metastable
		logic [WIDTH-1:0] safe;	// settled copy
	} chain_s;

	chain_s q;	// registered state
	chain_s next_q;	// next state

	// shift one stage per edge
	always_comb begin
		next_q      = q;
		next_q.meta = pin_in;
		next_q.safe = q.meta;
	end

	// reset to zero; idle level is applied by the caller
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	// safe stage, inverted by the caller's idle level mask
	assign sync_out = q.safe ^ reset_val;

endmodule // sync_stage

// File: logic/mem_clock_gen.sv
`timescale 1ns/1ps
module mem_clock_gen
	import static_mem_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// control
	input  wire logic en,
	// memory clock and edge marks
	output logic      mem_clk,
	output logic      rise,
	output logic      fall
);

	// ------------------------------------------------------------
	// divider, held low while no burst runs
	// ------------------------------------------------------------
	divider_s q;	// registered state
	divider_s next_q;	// next state

	// count phases; clock is a flop so it moves on bus clock edges only
	always_comb begin
		next_q      = q;
		next_q.rise = 1'b0;
		next_q.fall = 1'b0;
		if (!en) begin
			// stopped clock parks low
			next_q.cnt     = 4'h0;
			next_q.mem_clk = 1'b0;
		end else begin
			next_q.cnt     = (q.cnt == CLK_DIV - 4'h1) ? 4'h0 : q.cnt + 4'h1;
			next_q.mem_clk = (next_q.cnt >= CLK_HALF);
			next_q.rise    = next_q.mem_clk && !q.mem_clk;
			next_q.fall    = !next_q.mem_clk && q.mem_clk;
		end
	end

	// state register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			q <= DIVIDER_RESET;
		end else begin
			q <= next_q;
		end
	end

	assign mem_clk = q.mem_clk;
	assign rise    = q.rise;
	assign fall    = q.fall;

endmodule // mem_clock_gen

// File: logic/static_mem_ctrl.sv
// Behaviour
// - strobes, selects, lanes, wait are low active
// - non-muxed: only high address and bit0
// - two chip selects, 1 and 4, shared lines
// - muxed: low address and data share bus
// - drive low active address valid strobe
// - memory wait low stalls the transfer
// - memory clock runs only in bursts
// - lane 1 upper byte, lane 0 lower
// - 16-bit word addressed, 8+16 address lines
// - 32-bit access becomes two 16-bit accesses, or two beats of one burst
// - no asynchronous page reads
// - byte lanes qualify byte and sram accesses
// - refuse asynchronous byte writes to nor
// - no sync byte reads, sync writes psram
// - outputs move on bus clock rising edge
// - sync write data moves on clock fall
// - host bits 27:26 pick select 1 or 4
// - host bits 23:1 form word address
`timescale 1ns/1ps
module static_mem_ctrl
	import static_mem_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// configuration levels
	input  wire logic [1:0]  cfg_mem_type,
	input  wire logic        cfg_muxed,
	input  wire logic        cfg_sync,
	input  wire logic        cfg_wait_en,
	// host request
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire logic        req_write,
	input  wire logic [1:0]  req_size,
	input  wire logic [27:0] req_addr,
	input  wire logic [31:0] req_wdata,
	// host answer
	output logic             resp_valid,
	output logic             resp_error,
	output logic [31:0]      resp_rdata,
	// memory control pins
	output logic             mem_clk,
	output logic             bank_select_n_1,
	output logic             bank_select_n_4,
	output logic             output_strobe_n,
	output logic             write_strobe_n,
	output logic             address_valid_n,
	output logic [1:0]       byte_lane_enable_n,
	input  wire logic        memory_stall_n,
	// memory address and data pins
	output logic [7:0]       addr_high,
	output logic             addr_bit0,
	input  wire logic [15:0] data_in,
	output logic [15:0]      data_out,
	output logic             data_oe_n
);

	// ------------------------------------------------------------
	// pin synchronisers and memory clock
	// ------------------------------------------------------------
	logic        stall_n_sync;	// wait pin, settled
	logic [15:0] data_sync;	// read data pins, settled
	logic        clk_rise;	// memory clock went high
	logic        clk_fall;	// memory clock went low
	logic        stall;	// memory asks to wait

	// idle level of wait is high, so the chain is seeded inverted
	sync_stage #(.WIDTH(1)) u_stall_sync (
		.clk       (clk),
		.resetn    (resetn),
		.pin_in    (~memory_stall_n),
		.reset_val (1'b1),
		.sync_out  (stall_n_sync)
	);

	// read data needs setup of two bus clocks before strobe release
	sync_stage #(.WIDTH(16)) u_data_sync (
		.clk       (clk),
		.resetn    (resetn),
		.pin_in    (data_in),
		.reset_val (16'h0000),
		.sync_out  (data_sync)
	);

	access_s q;	// registered state
	access_s next_q;	// next state

	mem_clock_gen u_clock (
		.clk     (clk),
		.resetn  (resetn),
		.en      (q.clk_en),
		.mem_clk (mem_clk),
		.rise    (clk_rise),
		.fall    (clk_fall)
	);

	assign stall = cfg_wait_en && !stall_n_sync;

	// ------------------------------------------------------------
	// request screening
	// ------------------------------------------------------------
	logic [1:0] req_bank;	// host bank field
	logic       req_bad;	// access refused
	logic       is_nor;	// nor flash attached
	logic       is_sram;	// sram or rom attached
	logic       req_byte;	// byte sized request

	always_comb begin
		req_bank = req_addr[BANK_MSB:BANK_LSB];
		is_nor   = (cfg_mem_type == MEM_NOR);
		is_sram  = (cfg_mem_type == MEM_SRAM);
		req_byte = (req_size == SIZE_8);
		req_bad  = 1'b0;
		// only the two sub banks decode
		if (req_bank != BANK_SEL_1 && req_bank != BANK_SEL_4) begin
			req_bad = 1'b1;
		end
		if (req_size != SIZE_8 && req_size != SIZE_16 && req_size != SIZE_32) begin
			req_bad = 1'b1;
		end
		// byte writes would corrupt a nor word
		if (is_nor && !cfg_sync && req_write && req_byte) begin
			req_bad = 1'b1;
		end
		// bursts: no byte reads, writes on psram only, none on sram
		if (cfg_sync && (is_sram || (!req_write && req_byte) || (req_write && is_nor))) begin
			req_bad = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// access sequencer; page reads are never issued, one word per address except 32-bit bursts
	// ------------------------------------------------------------
	logic        more;	// second half still to go
	logic [15:0] cur_word;	// write half for this beat
	logic        active;	// a select is low

	always_comb begin
		next_q            = q;
		next_q.resp_valid = 1'b0;
		next_q.resp_error = 1'b0;
		more              = (q.size == SIZE_32) && !q.half;
		case (q.state)
			S_IDLE: begin
				if (req_valid) begin
					next_q.write = req_write;
					next_q.size  = req_size;
					next_q.wdata = req_wdata;
					next_q.waddr = req_addr[HADDR_MSB:1];
					next_q.half  = 1'b0;
					next_q.rdata = 32'h00000000;
					next_q.cs4   = (req_bank == BANK_SEL_4);
					// byte picks one lane, sram always lane qualified
					if (req_byte) begin
						next_q.lanes = req_addr[0] ? 2'h2 : 2'h1;
					end else begin
						next_q.lanes = 2'h3;
					end
					if (req_bad) begin
						next_q.resp_valid = 1'b1;
						next_q.resp_error = 1'b1;
					end else if (cfg_sync) begin
						next_q.state = S_SADDR;
					end else begin
						next_q.state = S_ADDR;
						next_q.cnt   = ADDR_SETUP_CYCLES;
					end
				end
			end
			S_ADDR: begin
				if (q.cnt > 8'h01) begin
					next_q.cnt = q.cnt - 8'h01;
				end else if (cfg_muxed) begin
					next_q.state = S_MUXHOLD;
					next_q.cnt   = ADDR_HOLD_CYCLES;
				end else begin
					next_q.state = S_DATA;
					next_q.cnt   = DATA_SETUP_CYCLES;
				end
			end
			S_MUXHOLD: begin
				if (q.cnt > 8'h01) begin
					next_q.cnt = q.cnt - 8'h01;
				end else begin
					next_q.state = S_DATA;
					next_q.cnt   = DATA_SETUP_CYCLES;
				end
			end
			S_DATA: begin
				if (stall) begin
					next_q.cnt = q.cnt;
				end else if (q.cnt > 8'h01) begin
					next_q.cnt = q.cnt - 8'h01;
				end else begin
					// sample before the strobe rises
					if (!q.write) begin
						if (q.half) begin
							next_q.rdata = {data_sync, q.rdata[15:0]};
						end else begin
							next_q.rdata = {q.rdata[31:16], data_sync};
						end
					end
					next_q.state = S_TURN;
					next_q.cnt   = TURN_CYCLES;
				end
			end
			S_TURN: begin
				if (q.cnt > 8'h01) begin
					next_q.cnt = q.cnt - 8'h01;
				end else if (more) begin
					// second half word, next word address
					next_q.half  = 1'b1;
					next_q.waddr = q.waddr + 23'h000001;
					next_q.state = S_ADDR;
					next_q.cnt   = ADDR_SETUP_CYCLES;
				end else begin
					next_q.state      = S_IDLE;
					next_q.resp_valid = 1'b1;
				end
			end
			S_SADDR: begin
				// memory latches the address on a rising clock
				if (clk_rise) begin
					next_q.state = S_SLAT;
					next_q.cnt   = SYNC_LATENCY;
				end
			end
			S_SLAT: begin
				if (clk_rise) begin
					if (q.cnt > 8'h01) begin
						next_q.cnt = q.cnt - 8'h01;
					end else begin
						next_q.state = S_SBEAT;
					end
				end
			end
			S_SBEAT: begin
				// a beat passes on a rising clock unless the memory waits
				if (clk_rise && !stall) begin
					if (!q.write) begin
						if (q.half) begin
							next_q.rdata = {data_sync, q.rdata[15:0]};
						end else begin
							next_q.rdata = {q.rdata[31:16], data_sync};
						end
					end
					if (more) begin
						next_q.half = 1'b1;
					end else begin
						next_q.state = S_TURN;
						next_q.cnt   = TURN_CYCLES;
					end
				end
			end
			default: begin
				next_q.state = S_IDLE;
			end
		endcase

		// pins follow the next state so all of them are flops
		active          = (next_q.state != S_IDLE) && (next_q.state != S_TURN);
		next_q.cs1_n    = !(active && !next_q.cs4);
		next_q.cs4_n    = !(active && next_q.cs4);
		next_q.adv_n    = !(next_q.state == S_ADDR || next_q.state == S_SADDR);
		next_q.a_hi     = {1'b0, next_q.waddr[22:16]};
		next_q.a0       = next_q.waddr[0];
		next_q.lanes_n  = active ? ~next_q.lanes : 2'h3;
		next_q.clk_en   = (next_q.state == S_SADDR) || (next_q.state == S_SLAT)
				|| (next_q.state == S_SBEAT);
		next_q.oe_n     = !(!next_q.write && (next_q.state == S_DATA
				|| next_q.state == S_SLAT || next_q.state == S_SBEAT));
		next_q.we_n     = !(next_q.write && (next_q.state == S_DATA
				|| (next_q.clk_en && next_q.state != S_SADDR)));
		cur_word        = next_q.half ? next_q.wdata[31:16] : next_q.wdata[15:0];
		next_q.d_oe_n   = 1'b1;
		if (cfg_muxed && (next_q.state == S_ADDR || next_q.state == S_MUXHOLD
				|| next_q.state == S_SADDR)) begin
			// low address rides the shared bus
			next_q.dout   = next_q.waddr[15:0];
			next_q.d_oe_n = 1'b0;
		end else if (next_q.write && next_q.state == S_DATA) begin
			next_q.dout   = cur_word;
			next_q.d_oe_n = 1'b0;
		end else if (next_q.write && (next_q.state == S_SLAT || next_q.state == S_SBEAT)) begin
			// burst write data moves only after a falling clock
			if (clk_fall) begin
				next_q.dout = cur_word;
			end
			next_q.d_oe_n = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// state register; every pin changes on the rising bus clock
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			q <= ACCESS_RESET;
		end else begin
			q <= next_q;
		end
	end

	assign req_ready          = (q.state == S_IDLE);
	assign resp_valid         = q.resp_valid;
	assign resp_error         = q.resp_error;
	assign resp_rdata         = q.rdata;
	assign bank_select_n_1    = q.cs1_n;
	assign bank_select_n_4    = q.cs4_n;
	assign output_strobe_n    = q.oe_n;
	assign write_strobe_n     = q.we_n;
	assign address_valid_n    = q.adv_n;
	assign byte_lane_enable_n = q.lanes_n;
	assign addr_high          = q.a_hi;
	assign addr_bit0          = q.a0;
	assign data_out           = q.dout;
	assign data_oe_n          = q.d_oe_n;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence take_bad_bank;
		req_valid && req_ready && req_addr[27:26] == 2'h1;
	endsequence
	sequence answer_refused;
		resp_valid && resp_error && bank_select_n_1 && bank_select_n_4;
	endsequence
	sequence take_nor_byte_write;
		req_valid && req_ready && !cfg_sync && cfg_mem_type == MEM_NOR
			&& req_write && req_size == SIZE_8;
	endsequence

	a_one_select: assert property (!(!bank_select_n_1 && !bank_select_n_4))
		else $error("both chip selects low");
	a_strobes_apart: assert property (!(!output_strobe_n && !write_strobe_n))
		else $error("read and write strobes low together");
	a_bank_refused: assert property (take_bad_bank |=> answer_refused)
		else $error("undecoded bank not refused");
	a_nor_byte: assert property (take_nor_byte_write |=> answer_refused)
		else $error("nor byte write not refused");
	a_clock_parked: assert property (q.state == S_DATA |-> !mem_clk && !clk_rise)
		else $error("memory clock runs in asynchronous access");
	a_read_release: assert property (!output_strobe_n |-> data_oe_n)
		else $error("bus driven while memory drives read data");
	a_high_addr: assert property (!address_valid_n
		|-> addr_high == {1'b0, q.waddr[22:16]} && addr_bit0 == q.waddr[0])
		else $error("high address pins wrong");
	a_stall_holds: assert property (q.state == S_DATA && stall && q.cnt == 8'h01
		|=> q.state == S_DATA && q.cnt == 8'h01)
		else $error("wait did not extend the transfer");
	a_burst_fall: assert property (!data_oe_n && q.state == S_SBEAT
		&& $past(q.state) == S_SBEAT && $changed(data_out) |-> $past(clk_fall))
		else $error("burst write data moved away from clock fall");
	a_byte_lane: assert property ($rose(q.state == S_ADDR) && q.size == SIZE_8
		|-> byte_lane_enable_n == ~q.lanes
		&& byte_lane_enable_n != 2'h0)
		else $error("byte access enabled both lanes");
	a_split_word: assert property ($rose(q.state == S_TURN) && q.size == SIZE_32 && !q.half
		|-> ##[1:8] q.state == S_ADDR && q.half)
		else $error("word access not split in two");

endmodule // static_mem_ctrl

// File: tb/mem_partner.sv
`timescale 1ns/1ps
module mem_partner (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// controller pins
	input  wire logic        sel_n,
	input  wire logic        output_strobe_n,
	input  wire logic        write_strobe_n,
	input  wire logic        address_valid_n,
	input  wire logic [1:0]  byte_lane_enable_n,
	input  wire logic [7:0]  addr_high,
	input  wire logic        addr_bit0,
	input  wire logic [15:0] data_out,
	input  wire logic        data_oe_n,
	// bench knobs
	input  wire logic        muxed,
	input  wire logic [7:0]  stall_len,
	// driven back
	output logic             memory_stall_n,
	output logic [15:0]      data_in
);
	logic [15:0] mem [0:511];	// small word store
	logic [15:0] last;		// last bus level
	logic        alat;		// low address bit latched off muxed bus
	logic [7:0]  scnt;		// stall countdown
	wire  [8:0]  idx = {addr_high, muxed ? alat : addr_bit0};
	// ----------------------------------------
	// read drive; released bus shows inverse so a stale value never passes
	// ----------------------------------------
	assign data_in = (!sel_n && !output_strobe_n) ? mem[idx] : ~last;
	assign memory_stall_n = (scnt == 8'h00);
	// stores, address latch and stall count
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			scnt <= 8'h00;
			last <= 16'h0000;
			alat <= 1'b0;
		end else begin
			last <= data_in;
			if (!address_valid_n && !data_oe_n)
				alat <= data_out[0];
			if ($fell(output_strobe_n) || $fell(write_strobe_n))
				scnt <= stall_len;
			else if (scnt != 8'h00)
				scnt <= scnt - 8'h01;
			if (!sel_n && !write_strobe_n) begin
				if (!byte_lane_enable_n[1]) mem[idx][15:8] <= data_out[15:8];
				if (!byte_lane_enable_n[0]) mem[idx][7:0] <= data_out[7:0];
			end
		end
	end
endmodule // mem_partner

// File: tb/nor_psram_bus_interface_bench.sv
`timescale 1ns/1ps
module nor_psram_bus_interface_bench;
	import static_mem_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic clk, resetn, cfg_muxed, cfg_sync, cfg_wait_en, req_valid, req_ready, req_write;
	logic resp_valid, resp_error, mem_clk, cs1_n, cs4_n, oe_n, we_n, adv_n, stall_n, a0, d_oe_n;
	logic [1:0]  cfg_mem_type, req_size, lanes_n, ln;
	logic [27:0] req_addr;
	logic [31:0] req_wdata, resp_rdata;
	logic [7:0]  ah, stall_len;
	logic [15:0] din, dout, ad;
	logic        cs1, cs4, ad_oe, pa0;
	int          error_cnt, n_tests, n_acc, n_mclk, lat;
	// ----------------------------------------
	// design and memory model
	// ----------------------------------------
	static_mem_ctrl dut (.clk(clk), .resetn(resetn), .cfg_mem_type(cfg_mem_type),
		.cfg_muxed(cfg_muxed), .cfg_sync(cfg_sync), .cfg_wait_en(cfg_wait_en),
		.req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
		.req_size(req_size), .req_addr(req_addr), .req_wdata(req_wdata),
		.resp_valid(resp_valid), .resp_error(resp_error), .resp_rdata(resp_rdata),
		.mem_clk(mem_clk), .bank_select_n_1(cs1_n), .bank_select_n_4(cs4_n),
		.output_strobe_n(oe_n), .write_strobe_n(we_n), .address_valid_n(adv_n),
		.byte_lane_enable_n(lanes_n), .memory_stall_n(stall_n), .addr_high(ah),
		.addr_bit0(a0), .data_in(din), .data_out(dout), .data_oe_n(d_oe_n));
	mem_partner partner (.clk(clk), .resetn(resetn), .sel_n(cs1_n & cs4_n),
		.output_strobe_n(oe_n), .write_strobe_n(we_n), .address_valid_n(adv_n),
		.byte_lane_enable_n(lanes_n), .addr_high(ah), .addr_bit0(a0), .data_out(dout),
		.data_oe_n(d_oe_n), .muxed(cfg_muxed), .stall_len(stall_len),
		.memory_stall_n(stall_n), .data_in(din));
	// 200 MHz bus clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// pin watcher: counts accesses and clock edges, keeps address phase
	always @(posedge clk) if (resetn) begin
		if ($fell(oe_n) || $fell(we_n)) n_acc++;
		if ($rose(mem_clk)) n_mclk++;
		if (!cs1_n) cs1 = 1'b1;
		if (!cs4_n) cs4 = 1'b1;
		if (!we_n) ln = lanes_n;
		if (!adv_n) begin
			ad = dout;
			ad_oe = d_oe_n;
			pa0 = a0;
		end
		if (!oe_n && !d_oe_n) chk_bit(1'b1, 1'b0);
	end
	// ----------------------------------------
	// compare and closing tasks
	// ----------------------------------------
	task automatic chk_bit(input logic g, input logic e);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %0t flag got %b want %b", $time, g, e);
		end
	endtask
	task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %0t value got %h want %h", $time, g, e);
		end
	endtask
	task automatic print_verdict();
		$display("errors %0d comparisons %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// mode levels, changed only while idle
	task automatic setcfg(input logic [1:0] t, input logic m, input logic s, input logic w);
		@(posedge clk);
		cfg_mem_type <= t;
		cfg_muxed <= m;
		cfg_sync <= s;
		cfg_wait_en <= w;
	endtask
	// one host request; lat counts cycles from take to answer
	task automatic host(input logic wr, input logic [1:0] sz, input logic [27:0] a,
			input logic [31:0] wd);
		{n_acc, n_mclk, lat, cs1, cs4} = '0;
		@(posedge clk);
		{req_write, req_size, req_addr, req_wdata, req_valid} <= {wr, sz, a, wd, 1'b1};
		@(negedge clk);
		while (req_ready !== 1'b1) @(negedge clk);
		@(posedge clk);
		req_valid <= 1'b0;
		do begin
			@(negedge clk);
			lat++;
		end while (resp_valid !== 1'b1 && lat < 400);
		if (lat >= 400) chk_bit(1'b0, 1'b1);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		chk_data({cs1_n, cs4_n, oe_n, we_n, adv_n, lanes_n, d_oe_n, mem_clk}, 32'h000001fe);
	endtask
	task automatic t_half(input logic m);
		setcfg(MEM_PSRAM, m, 1'b0, 1'b0);
		host(1'b1, SIZE_16, 28'h0a4b46, 32'h0000c3a5);
		chk_data({cs1, cs4, n_acc[1:0], n_mclk[1:0]}, 32'h00000024);
		chk_data({ah, pa0}, {8'h05, 1'b1});
		if (m) chk_data({ad_oe, ad}, {1'b0, 16'h25a3});
		host(1'b1, SIZE_8, 28'h0a4b47, 32'h00007e00);
		chk_data(ln, 2'b01);
		host(1'b0, SIZE_16, 28'h0a4b46, 32'h0);
		chk_data({resp_error, resp_rdata[15:0]}, {1'b0, 16'h7ea5});
	endtask
	task automatic t_word();
		setcfg(MEM_SRAM, 1'b0, 1'b0, 1'b0);
		host(1'b1, SIZE_32, 28'hc000010, 32'h8765_4321);
		chk_data({cs1, cs4, n_acc[2:0]}, 32'h0000000a);
		host(1'b0, SIZE_32, 28'hc000010, 32'h0);
		chk_data(resp_rdata, 32'h8765_4321);
		chk_data(n_acc, 2);
	endtask
	task automatic t_refuse();
		logic [33:0] tb [6];
		tb = '{{MEM_PSRAM, 1'b0, 1'b1, SIZE_16, 28'h4000000}, {MEM_PSRAM, 1'b0, 1'b0, 2'h3, 28'h0},
			{MEM_NOR, 1'b0, 1'b1, SIZE_8, 28'h0}, {MEM_SRAM, 1'b1, 1'b0, SIZE_16, 28'h0},
			{MEM_PSRAM, 1'b1, 1'b0, SIZE_8, 28'h0}, {MEM_NOR, 1'b1, 1'b1, SIZE_16, 28'h0}};
		foreach (tb[i]) begin
			setcfg(tb[i][33:32], 1'b0, tb[i][31], 1'b0);
			host(tb[i][30], tb[i][29:28], tb[i][27:0], 32'h0);
			chk_data({resp_error, cs1, cs4, n_acc[1:0]}, 32'h00000010);
		end
		setcfg(MEM_NOR, 1'b0, 1'b0, 1'b0);
		host(1'b0, SIZE_8, 28'h0a4b47, 32'h0);
		chk_data({resp_error, resp_rdata[15:0]}, {1'b0, 16'h7ea5});
	endtask
	task automatic t_stall();
		int l0;
		setcfg(MEM_NOR, 1'b0, 1'b0, 1'b1);
		host(1'b0, SIZE_16, 28'h0a4b46, 32'h0);
		l0 = lat;
		stall_len <= 8'h08;
		host(1'b0, SIZE_16, 28'h0a4b46, 32'h0);
		chk_bit(lat >= l0 + 6, 1'b1);
		chk_data(resp_rdata[15:0], 16'h7ea5);
		stall_len <= 8'h00;
	endtask
	task automatic t_sync();
		setcfg(MEM_PSRAM, 1'b0, 1'b1, 1'b0);
		host(1'b1, SIZE_16, 28'h0000020, 32'h00005a0f);
		chk_bit(n_mclk > 0, 1'b1);
		host(1'b0, SIZE_16, 28'h0000020, 32'h0);
		chk_data({resp_error, resp_rdata[15:0]}, {1'b0, 16'h5a0f});
		chk_bit(n_mclk > 2, 1'b1);
	endtask
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		{resetn, req_valid, req_write, req_size, req_addr, req_wdata} = '0;
		{cfg_mem_type, cfg_muxed, cfg_sync, cfg_wait_en, stall_len} = '0;
		{error_cnt, n_tests} = '0;
		repeat (5) @(posedge clk);
		t_reset();
		resetn <= 1'b1;
		t_half(1'b0);
		t_half(1'b1);
		t_word();
		t_refuse();
		t_stall();
		t_sync();
		print_verdict();
	end
	initial begin
		#150000;
		error_cnt++;
		print_verdict();
	end
endmodule // nor_psram_bus_interface_bench
